// *** rtl/tpwm_gen.v ***
// Three-phase PWM generator with dead time, chopping and trip shutdown.
//
// The implementer's own choices: the register addresses and strobed register access.

`include "tpwm_regs.vh"

module tpwm_gen (
	input  wire        i_clk_sys,
	input  wire        i_reset,
	input  wire        i_clk_en,
	input  wire [3:0]  i_addr,
	input  wire [15:0] i_wr_data,
	input  wire        i_wr,
	input  wire        i_rd,
	input  wire        i_output_polarity_pin,
	input  wire        i_reluctance_mode_pin,
	input  wire        i_shutdown_pin_n,
	input  wire        i_flag_io_trip,
	input  wire        i_ext_sync,
	output reg  [15:0] o_rd_data,
	output reg         o_period_sync,
	output reg         o_sync_irq_flag,
	output reg         o_shutdown_irq_flag,
	output wire        o_phase_a_upper_out,
	output wire        o_phase_a_lower_out,
	output wire        o_phase_b_upper_out,
	output wire        o_phase_b_lower_out,
	output wire        o_phase_c_upper_out,
	output wire        o_phase_c_lower_out
);

	// ****************************************************************
	// Software registers
	// ****************************************************************

	reg  [4:0]  main_control;
	reg  [15:0] half_period;
	reg  [9:0]  dead_time;
	reg  [47:0] duty_sw;
	reg  [8:0]  output_steering;
	reg  [9:0]  gate_chopping;
	reg  [9:0]  sync_width;

	// Shadow copies used by the timing unit.
	reg  [15:0] sh_tm;
	reg  [9:0]  sh_dt;
	reg  [47:0] sh_du;
	reg  [8:0]  sh_steer;

	// Trip and external sync synchronisers.
	reg         trip_m;
	reg         trip_s;
	reg         ext_m;
	reg         ext_s;
	reg         ext_q;

	// Timing unit state.
	reg  [16:0] cnt;
	reg  [9:0]  sync_cnt;
	reg  [7:0]  chop_cnt;
	reg         chop_ph;
	wire [5:0]  act;

	wire        gen_en;
	wire        dbl;
	wire        ext_sel;
	wire        sync_en;
	wire        run;
	wire        trip_raw;
	wire        ext_lvl;
	wire        ext_edge;
	wire [16:0] per_last;
	wire        first_half;
	wire        cnt_end;
	wire        start;
	wire        mid;
	wire        load;
	wire        sync_evt;
	wire [16:0] pos;
	wire        pol;

	assign gen_en  = main_control[`TPWM_C_EN];
	assign dbl     = main_control[`TPWM_C_DBL];
	assign ext_sel = main_control[`TPWM_C_EXT];
	assign sync_en = main_control[`TPWM_C_SEN];
	assign run     = gen_en | sync_en;
	assign pol     = i_output_polarity_pin;

	// ****************************************************************
	// Trip detection
	// ****************************************************************

	// Either trip source drives the same unclocked shutdown path.
	assign trip_raw = ~i_shutdown_pin_n | i_flag_io_trip;

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			trip_m <= 1'b0;
			trip_s <= 1'b0;
		end else if (i_clk_en) begin
			trip_m <= trip_raw;
			trip_s <= trip_m;
		end
	end

	// ****************************************************************
	// External sync selection
	// ****************************************************************

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			ext_m <= 1'b0;
			ext_s <= 1'b0;
			ext_q <= 1'b0;
		end else if (i_clk_en) begin
			ext_m <= i_ext_sync;
			ext_s <= ext_m;
			ext_q <= ext_lvl;
		end
	end

	// The raw path saves two cycles of latency but is only safe when the
	// source is already synchronous to this clock.
	assign ext_lvl = main_control[`TPWM_C_SYN] ?
		ext_s : i_ext_sync;
	// Pulses of at least one clock are relied on to be seen here.
	assign ext_edge = ext_lvl & ~ext_q;

	// ****************************************************************
	// Period counter
	// ****************************************************************

	// A full period is twice the half period count.
	assign per_last   = {sh_tm, 1'b0} - 17'h00001;
	assign first_half = cnt < {1'b0, sh_tm};
	assign cnt_end    = cnt >= per_last;
	assign start      = ext_sel ? ext_edge : cnt_end;
	assign mid        = cnt == ({1'b0, sh_tm} - 17'h00001);
	// Shadows reload at the start, and at the midpoint in double mode.
	assign load       = ~run | start | (mid & dbl);
	assign sync_evt   = run & (start | (mid & dbl));
	assign pos        = first_half ? cnt : per_last - cnt;

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			cnt      <= 17'h00000;
			sh_tm    <= `TPWM_R_TM;
			sh_dt    <= `TPWM_R_DT;
			sh_du    <= {3{`TPWM_R_DU}};
			sh_steer <= `TPWM_R_STEER;
		end else if (i_clk_en) begin
			if (!run || start || cnt_end) begin
				cnt <= 17'h00000;
			end else begin
				cnt <= cnt + 17'h00001;
			end
			if (load) begin
				sh_tm    <= half_period;
				sh_dt    <= dead_time;
				sh_du    <= duty_sw;
				sh_steer <= output_steering;
			end
		end
	end

	// ****************************************************************
	// Sync pulse generator
	// ****************************************************************

	// The pulse keeps running during a trip while sync stays enabled.
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			sync_cnt      <= 10'h000;
			o_period_sync <= 1'b0;
		end else if (i_clk_en) begin
			if (sync_evt && sync_en) begin
				sync_cnt      <= sync_width;
				o_period_sync <= sync_width != 10'h000;
			end else if (sync_cnt != 10'h000) begin
				sync_cnt      <= sync_cnt - 10'h001;
				o_period_sync <= sync_cnt != 10'h001;
			end else begin
				o_period_sync <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Chopping clock
	// ****************************************************************

	// Chop frequency is the clock over twice (field plus one).
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			chop_cnt <= 8'h00;
			chop_ph  <= 1'b0;
		end else if (i_clk_en) begin
			if (chop_cnt >= gate_chopping[7:0]) begin
				chop_cnt <= 8'h00;
				chop_ph  <= ~chop_ph;
			end else begin
				chop_cnt <= chop_cnt + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Per-phase ideal pair, crossover, dead time and gating
	// ****************************************************************

	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_phase
			reg  [10:0] dtc;
			reg         last;
			reg         up_q;
			reg         lo_q;
			wire        ideal;
			wire        xo;
			wire        up_on;
			wire        lo_on;
			wire        up_ch;
			wire        lo_ch;

			// Center-based compare gives one pulse per period, symmetric about the midpoint.
			assign ideal = ({1'b0, pos[15:0]} +
				{1'b0, sh_du[16*k +: 16]}) >=
				{1'b0, sh_tm};
			assign xo    = ideal ^ sh_steer[`TPWM_S_XO + k];
			assign up_on = last & (dtc == 11'h000);
			assign lo_on = ~last & (dtc == 11'h000);
			assign up_ch = ~gate_chopping[`TPWM_G_UEN] | chop_ph;
			assign lo_ch = ~gate_chopping[`TPWM_G_LEN] | chop_ph;
			assign act[2*k]   = up_q;
			assign act[2*k+1] = lo_q;

			always @(posedge i_clk_sys) begin
				if (i_reset) begin
					dtc        <= 11'h000;
					last       <= 1'b0;
					up_q       <= 1'b0;
					lo_q       <= 1'b0;
				end else if (i_clk_en) begin
					// Both sides stay off for the dead interval.
					if (xo != last) begin
						last <= xo;
						dtc  <= {sh_dt, 1'b0};
					end else if (dtc != 11'h000) begin
						dtc <= dtc - 11'h001;
					end
					up_q <= up_on & gen_en &
						sh_steer[2*k] & up_ch;
					lo_q <= lo_on & gen_en &
						sh_steer[2*k+1] & lo_ch;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Gate drive
	// ****************************************************************

	// The trip term bypasses every flop so a dead clock cannot hold a
	// switch on; the cost is one gate level after the output flops.
	assign o_phase_a_upper_out =
		~((act[0] & ~trip_raw) ^ pol);
	assign o_phase_a_lower_out =
		~((act[1] & ~trip_raw) ^ pol);
	assign o_phase_b_upper_out =
		~((act[2] & ~trip_raw) ^ pol);
	assign o_phase_b_lower_out =
		~((act[3] & ~trip_raw) ^ pol);
	assign o_phase_c_upper_out =
		~((act[4] & ~trip_raw) ^ pol);
	assign o_phase_c_lower_out =
		~((act[5] & ~trip_raw) ^ pol);

	// ****************************************************************
	// Register writes and event flags
	// ****************************************************************

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			main_control        <= `TPWM_R_CTRL;
			half_period         <= `TPWM_R_TM;
			dead_time           <= `TPWM_R_DT;
			duty_sw             <= {3{`TPWM_R_DU}};
			output_steering     <= `TPWM_R_STEER;
			gate_chopping       <= `TPWM_R_GATE;
			sync_width          <= `TPWM_R_SWID;
			o_sync_irq_flag     <= 1'b0;
			o_shutdown_irq_flag <= 1'b0;
		end else if (i_clk_en) begin
			if (i_wr) begin
				case (i_addr)
				`TPWM_A_CTRL:  main_control <= i_wr_data[4:0];
				`TPWM_A_TM:    half_period <= i_wr_data;
				`TPWM_A_DT:    dead_time <= i_wr_data[9:0];
				`TPWM_A_DUA:   duty_sw[15:0] <= i_wr_data;
				`TPWM_A_DUB:   duty_sw[31:16] <= i_wr_data;
				`TPWM_A_DUC:   duty_sw[47:32] <= i_wr_data;
				`TPWM_A_STEER: output_steering <= i_wr_data[8:0];
				`TPWM_A_GATE:  gate_chopping <= i_wr_data[9:0];
				`TPWM_A_SWID:  sync_width <= i_wr_data[9:0];
				`TPWM_A_STAT: begin
					if (i_wr_data[`TPWM_ST_SIRQ]) begin
						o_sync_irq_flag <= 1'b0;
					end
					if (i_wr_data[`TPWM_ST_TIRQ]) begin
						o_shutdown_irq_flag <= 1'b0;
					end
				end
				default: begin
				end
				endcase
			end
			// Hardware sets come last so they win over a clear.
			if (trip_s) begin
				main_control[`TPWM_C_EN] <= 1'b0;
				o_shutdown_irq_flag      <= 1'b1;
			end
			if (sync_evt && sync_en && sync_width != 10'h000 &&
				!o_period_sync) begin
				o_sync_irq_flag <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_rd_data <= 16'h0000;
		end else if (i_clk_en) begin
			o_rd_data <= 16'h0000;
			if (i_rd) begin
				case (i_addr)
				`TPWM_A_CTRL:  o_rd_data <= {11'h000, main_control};
				`TPWM_A_TM:    o_rd_data <= half_period;
				`TPWM_A_DT:    o_rd_data <= {6'h00, dead_time};
				`TPWM_A_DUA:   o_rd_data <= duty_sw[15:0];
				`TPWM_A_DUB:   o_rd_data <= duty_sw[31:16];
				`TPWM_A_DUC:   o_rd_data <= duty_sw[47:32];
				`TPWM_A_STEER: o_rd_data <= {7'h00, output_steering};
				`TPWM_A_GATE:  o_rd_data <= {6'h00, gate_chopping};
				`TPWM_A_SWID:  o_rd_data <= {6'h00, sync_width};
				`TPWM_A_STAT: begin
					o_rd_data <= {6'h00,
						o_shutdown_irq_flag,
						o_sync_irq_flag,
						3'h0,
						~first_half,
						i_reluctance_mode_pin,
						pol,
						i_flag_io_trip,
						i_shutdown_pin_n};
				end
				default:       o_rd_data <= 16'h0000;
				endcase
			end
		end
	end

endmodule

// *** rtl/tpwm_regs.vh ***
// Register map, field positions and reset values of the PWM generator.
`ifndef TPWM_REGS_VH
`define TPWM_REGS_VH

// Register word addresses.
`define TPWM_A_CTRL  4'h0
`define TPWM_A_TM    4'h1
`define TPWM_A_DT    4'h2
`define TPWM_A_DUA   4'h3
`define TPWM_A_DUB   4'h4
`define TPWM_A_DUC   4'h5
`define TPWM_A_STEER 4'h6
`define TPWM_A_GATE  4'h7
`define TPWM_A_SWID  4'h8
`define TPWM_A_STAT  4'h9

// Main control fields.
`define TPWM_C_EN  0
`define TPWM_C_DBL 1
`define TPWM_C_EXT 2
`define TPWM_C_SYN 3
`define TPWM_C_SEN 4

// Steering and chopping fields.
`define TPWM_S_XO  6
`define TPWM_G_UEN 8
`define TPWM_G_LEN 9

// Status fields.
`define TPWM_ST_TRIP 0
`define TPWM_ST_FLAG 1
`define TPWM_ST_POL  2
`define TPWM_ST_REL  3
`define TPWM_ST_HALF 4
`define TPWM_ST_SIRQ 8
`define TPWM_ST_TIRQ 9

// Reset values.
`define TPWM_R_CTRL  5'h00
`define TPWM_R_TM    16'h0400
`define TPWM_R_DT    10'h000
`define TPWM_R_DU    16'h0000
`define TPWM_R_STEER 9'h03F
`define TPWM_R_GATE  10'h000
`define TPWM_R_SWID  10'h001

`endif

// *** verif/tpwm_gate_drv.sv ***
// Gate-driver model that counts cycles in which any leg has both switches on.
module tpwm_gate_drv (
	input  wire logic       i_clk_sys,
	input  wire logic       i_polarity,
	input  wire logic [5:0] i_gates,
	output int              o_shoot
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] on;
	int         n_shoot = 0;
	assign on = i_gates ^ {6{~i_polarity}};
	assign o_shoot = n_shoot;
	// Shoot-through would short the link, so any overlap is counted.
	always @(posedge i_clk_sys) begin
		if ((on[5] & on[4]) | (on[3] & on[2]) | (on[1] & on[0])) begin
			n_shoot <= n_shoot + 1;
		end
	end
endmodule

// *** verif/tpwm_gen_assertions.sv ***
// Port checker for the PWM generator.
module tpwm_gen_chk (
	input wire logic        i_clk_sys,
	input wire logic        i_reset,
	input wire logic        i_clk_en,
	input wire logic [3:0]  i_addr,
	input wire logic [15:0] i_wr_data,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic        i_output_polarity_pin,
	input wire logic        i_reluctance_mode_pin,
	input wire logic        i_shutdown_pin_n,
	input wire logic        i_flag_io_trip,
	input wire logic        i_ext_sync,
	input wire logic [15:0] o_rd_data,
	input wire logic        o_period_sync,
	input wire logic        o_sync_irq_flag,
	input wire logic        o_shutdown_irq_flag,
	input wire logic        o_phase_a_upper_out,
	input wire logic        o_phase_a_lower_out,
	input wire logic        o_phase_b_upper_out,
	input wire logic        o_phase_b_lower_out,
	input wire logic        o_phase_c_upper_out,
	input wire logic        o_phase_c_lower_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********************************
	// Checks
	// ********************************
	wire logic [5:0] outs = {o_phase_a_upper_out, o_phase_a_lower_out,
		o_phase_b_upper_out, o_phase_b_lower_out,
		o_phase_c_upper_out, o_phase_c_lower_out};
	wire logic [5:0] on = outs ^ {6{~i_output_polarity_pin}};
	wire logic off = (on == 6'h00);
	wire logic trip = ~i_shutdown_pin_n | i_flag_io_trip;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	sequence s_trip3;
		(trip && i_clk_en) [*3];
	endsequence
	sequence s_quiet;
		(!trip && !i_wr) [*4];
	endsequence
	AST_TRIP_OFF: assert property (!i_shutdown_pin_n |-> off)
		else $error("outputs not off during pin trip");
	AST_FLAG_OFF: assert property (i_flag_io_trip |-> off)
		else $error("outputs not off during flag trip");
	AST_PAIR_EXCL: assert property (!(on[5] && on[4]) &&
		!(on[3] && on[2]) && !(on[1] && on[0]))
		else $error("both switches of a leg on");
	AST_TRIP_IRQ: assert property (s_trip3 |=> o_shutdown_irq_flag)
		else $error("shutdown flag not set");
	AST_TRIP_HOLD: assert property (s_trip3 ##1 s_quiet |-> off)
		else $error("outputs resumed after trip");
	AST_SYNC_IRQ: assert property ($rose(o_period_sync) |-> o_sync_irq_flag)
		else $error("sync flag missing at pulse rise");
	AST_SYNC_HOLD: assert property (o_sync_irq_flag && i_clk_en &&
		!(i_wr && i_addr == 4'h9 && i_wr_data[8]) |=> o_sync_irq_flag)
		else $error("sync flag dropped");
	AST_SHUT_CLR: assert property ((!trip) [*4] ##0 (i_wr && i_clk_en &&
		i_addr == 4'h9 && i_wr_data[9]) |=> !o_shutdown_irq_flag)
		else $error("shutdown flag not cleared");
	AST_RD_STAT: assert property (i_rd && i_clk_en && i_addr == 4'h9 |=>
		o_rd_data[3:2] == {$past(i_reluctance_mode_pin),
		$past(i_output_polarity_pin)})
		else $error("status pin bits wrong");
endmodule
bind tpwm_gen tpwm_gen_chk u_chk (.*);

// *** verif/tpwm_gen_test.sv ***
// Self-checking bench for the PWM generator.
`include "tpwm_regs.vh"
module tpwm_gen_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic        pol = 1'b1, rel = 1'b1, trip_n = 1'b1, ftrip = 1'b0;
	logic        esync = 1'b0, en = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdat = 16'h0000;
	logic [15:0] d;
	wire  [15:0] rdat;
	wire  [5:0]  g;
	wire         psync, sirq, tirq;
	int          n_fail = 0, num_checks = 0, cyc = 0, shoot, t0, t1, n;
	always #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	tpwm_gen u_dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(en),
		.i_addr(addr), .i_wr_data(wdat), .i_wr(wr), .i_rd(rd),
		.i_output_polarity_pin(pol), .i_reluctance_mode_pin(rel),
		.i_shutdown_pin_n(trip_n), .i_flag_io_trip(ftrip),
		.i_ext_sync(esync), .o_rd_data(rdat), .o_period_sync(psync),
		.o_sync_irq_flag(sirq), .o_shutdown_irq_flag(tirq),
		.o_phase_a_upper_out(g[5]), .o_phase_a_lower_out(g[4]),
		.o_phase_b_upper_out(g[3]), .o_phase_b_lower_out(g[2]),
		.o_phase_c_upper_out(g[1]), .o_phase_c_lower_out(g[0]));
	tpwm_gate_drv u_drv (.i_clk_sys(clk), .i_polarity(pol), .i_gates(g),
		.o_shoot(shoot));
	// ********************************
	// Helpers
	// ********************************
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	// Waits for a rising sync pulse and returns its cycle.
	task automatic wsync(output int t);
		int i;
		logic p;
		p = 1'b1;
		for (i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			if (psync === 1'b1 && p === 1'b0) break;
			p = psync;
		end
		if (i == 3000) begin
			n_fail++;
			final_report;
		end
		t = cyc;
	endtask
	// Length in cycles of the next whole active pulse on one output.
	task automatic hlen(input int k, output int len);
		int i;
		len = 0;
		for (i = 0; i < 200 && g[k] === pol; i++) begin
			@(posedge clk);
			#1;
		end
		for (i = 0; i < 200 && g[k] !== pol; i++) begin
			@(posedge clk);
			#1;
		end
		for (i = 0; i < 200 && g[k] === pol; i++) begin
			@(posedge clk);
			#1;
			len++;
		end
	endtask
	task automatic settle;
		wsync(t0);
		wsync(t0);
	endtask
	// Counts active cycles of one output over a full 32-cycle period.
	task automatic cnt(input int k, input int exp);
		int c;
		c = 0;
		repeat (32) begin
			@(posedge clk);
			#1 c += (g[k] === pol);
		end
		chk(16'(c), 16'(exp));
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_regs;
		rreg(`TPWM_A_TM);
		chk(d, `TPWM_R_TM);
		rreg(`TPWM_A_STEER);
		chk(d, {7'h00, `TPWM_R_STEER});
		rreg(`TPWM_A_SWID);
		chk(d, {6'h00, `TPWM_R_SWID});
		wreg(`TPWM_A_DT, 16'hFFFF);
		rreg(`TPWM_A_DT);
		chk(d, 16'h03FF);
		wreg(4'hF, 16'hFFFF);
		rreg(4'hF);
		chk(d, 16'h0000);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h000C, 16'h000C);
		@(posedge clk);
		rel <= 1'b0;
		rreg(`TPWM_A_STAT);
		chk(d & 16'h000C, 16'h0004);
		wreg(`TPWM_A_DT, 16'h0000);
		@(posedge clk);
		en <= 1'b0;
		wreg(`TPWM_A_DT, 16'h0005);
		en <= 1'b1;
		rreg(`TPWM_A_DT);
		chk(d, 16'h0000);
		$display("regs done");
	endtask
	task automatic t_sync;
		wreg(`TPWM_A_TM, 16'h0010);
		wreg(`TPWM_A_SWID, 16'h0003);
		wreg(`TPWM_A_CTRL, 16'h0011);
		wsync(t0);
		for (n = 1; n < 20; n++) begin
			@(posedge clk);
			#1;
			if (psync !== 1'b1) break;
		end
		chk(16'(n), 16'h0003);
		wsync(t1);
		chk(16'(t1 - t0), 16'h0020);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h0100, 16'h0100);
		wreg(`TPWM_A_STAT, 16'h0100);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h0100, 16'h0000);
		wreg(`TPWM_A_CTRL, 16'h0013);
		settle;
		wsync(t1);
		chk(16'(t1 - t0), 16'h0010);
		wreg(`TPWM_A_CTRL, 16'h0011);
		settle;
		$display("sync done");
	endtask
	task automatic t_dead;
		wreg(`TPWM_A_DT, 16'h0002);
		wreg(`TPWM_A_DUA, 16'h0008);
		settle;
		for (n = 0; n < 64 && g[5] !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		for (n = 0; n < 64 && g[5] === 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(16'(n), 16'h000C);
		for (n = 0; n < 64 && g[4] !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk(16'(n), 16'h0004);
		wreg(`TPWM_A_STEER, 16'h007F);
		settle;
		hlen(5, n);
		chk(16'(n), 16'h000C);
		wreg(`TPWM_A_STEER, 16'h003F);
		wreg(`TPWM_A_DT, 16'h0000);
		$display("dead done");
	endtask
	task automatic t_steer;
		wreg(`TPWM_A_DUA, 16'h0004);
		settle;
		cnt(5, 8);
		wreg(`TPWM_A_STEER, 16'h007F);
		settle;
		cnt(5, 24);
		wreg(`TPWM_A_STEER, 16'h0000);
		settle;
		cnt(5, 0);
		cnt(4, 0);
		@(posedge clk);
		pol <= 1'b0;
		wreg(`TPWM_A_STEER, 16'h003F);
		settle;
		cnt(5, 8);
		@(posedge clk);
		pol <= 1'b1;
		$display("steer done");
	endtask
	task automatic t_chop;
		wreg(`TPWM_A_DUA, 16'h0010);
		wreg(`TPWM_A_GATE, 16'h0100);
		settle;
		cnt(5, 16);
		wreg(`TPWM_A_GATE, 16'h0107);
		settle;
		cnt(5, 16);
		wreg(`TPWM_A_GATE, 16'h0200);
		settle;
		cnt(5, 32);
		wreg(`TPWM_A_GATE, 16'h0000);
		$display("chop done");
	endtask
	task automatic t_trip;
		@(posedge clk);
		trip_n <= 1'b0;
		#1 chk({10'h000, g}, 16'h0000);
		wreg(`TPWM_A_CTRL, 16'h0011);
		repeat (3) @(posedge clk);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h0201, 16'h0200);
		rreg(`TPWM_A_CTRL);
		chk(d, 16'h0010);
		rreg(`TPWM_A_TM);
		chk(d, 16'h0010);
		trip_n <= 1'b1;
		repeat (5) @(posedge clk);
		wreg(`TPWM_A_STAT, 16'h0200);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h0200, 16'h0000);
		wreg(`TPWM_A_CTRL, 16'h0011);
		ftrip <= 1'b1;
		#1 chk({10'h000, g}, 16'h0000);
		repeat (4) @(posedge clk);
		rreg(`TPWM_A_STAT);
		chk(d & 16'h0202, 16'h0202);
		ftrip <= 1'b0;
		repeat (5) @(posedge clk);
		wreg(`TPWM_A_STAT, 16'h0200);
		wreg(`TPWM_A_CTRL, 16'h0011);
		settle;
		cnt(5, 32);
		wreg(`TPWM_A_CTRL, 16'h0010);
		settle;
		cnt(5, 0);
		$display("trip done");
	endtask
	task automatic t_ext;
		logic [15:0] modes [2];
		modes = '{16'h0015, 16'h001D};
		wreg(`TPWM_A_TM, 16'h0100);
		foreach (modes[m]) begin
			wreg(`TPWM_A_CTRL, modes[m]);
			repeat (2) begin
				repeat (100) @(posedge clk);
				esync <= 1'b1;
				for (n = 0; n < 10 && psync !== 1'b1; n++) begin
					@(posedge clk);
					if (n == 3) esync <= 1'b0;
					#1;
				end
				chk(16'(n), 16'(1 + 2 * m));
				repeat (4) @(posedge clk);
				esync <= 1'b0;
			end
		end
		chk(16'(shoot), 16'h0000);
		$display("ext done");
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_sync;
		t_dead;
		t_steer;
		t_chop;
		t_trip;
		t_ext;
		final_report;
	end
endmodule
